// [hdl/bfiu_defs.svh]
// Summary of operation
// RULE_01: io bit set forces one, two cycles
// RULE_02: io bit clear forces zero, two cycles
// RULE_03: rotate left through carry, flags, one cycle
// RULE_04: rotate right through carry, flags, one cycle
// RULE_05: copy register bit into transfer flag
// RULE_06: copy transfer flag into register bit
// RULE_07: set or clear half carry only
// RULE_08: set signed flag, others unchanged
// RULE_09: sleep pulses power management, no flags
// RULE_10: watchdog restart pulse, no flags
// RULE_11: break only requests debug stop
// RULE_12: shifts one cycle, carry gets shifted bit
// RULE_13: nibble swap one cycle, no flags
`ifndef BFIU_DEFS_SVH
`define BFIU_DEFS_SVH

// apb byte offsets, then region codes compared with upper paddr bits
`define BFIU_CMD_OFS       12'h000
`define BFIU_STATUS_OFS    12'h004
`define BFIU_FLAGS_OFS     12'h008
`define BFIU_WREG_BASE     5'h02
`define BFIU_IO_BASE       4'h2

// status register bit positions
`define BFIU_ST_BUSY_BIT   0
`define BFIU_ST_HALT_BIT   1
`define BFIU_ST_FLAGS_LSB  8

// flag register bit positions
`define BFIU_FLAG_C        0
`define BFIU_FLAG_Z        1
`define BFIU_FLAG_N        2
`define BFIU_FLAG_V        3
`define BFIU_FLAG_S        4
`define BFIU_FLAG_H        5
`define BFIU_FLAG_T        6

// reset values
`define BFIU_FLAGS_RST     8'h00
`define BFIU_CMD_RST       19'h00000

// cycle counts per instruction class
`define BFIU_IO_OP_CYCLES  2
`define BFIU_ALU_OP_CYCLES 1

`endif

// [hdl/bfiu_pkg.sv]
package bfiu_pkg;

	// instruction codes carried in the command word
	typedef enum logic [4:0] {
		nop_op                  = 5'h00,
		io_bit_set_op           = 5'h01,
		io_bit_clear_op         = 5'h02,
		rotate_left_carry_op    = 5'h03,
		rotate_right_carry_op   = 5'h04,
		shift_left_op           = 5'h05,
		shift_right_op          = 5'h06,
		arith_shift_right_op    = 5'h07,
		nibble_swap_op          = 5'h08,
		bit_to_transfer_flag_op = 5'h09,
		transfer_flag_to_bit_op = 5'h0a,
		half_carry_set_op       = 5'h0b,
		half_carry_clear_op     = 5'h0c,
		sign_flag_set_op        = 5'h0d,
		sleep_op                = 5'h0e,
		watchdog_restart_op     = 5'h0f,
		break_op                = 5'h10
	} bfiu_op_t;

	// execution sequencer states
	typedef enum logic [1:0] {
		st_idle     = 2'b00,
		st_exec     = 2'b01,
		st_io_read  = 2'b10,
		st_io_write = 2'b11
	} bfiu_state_t;

	// command word, bits 18:0 of a write to the command register
	typedef struct packed {
		logic [5:0] io_addr;
		logic [2:0] bit_sel;
		logic [4:0] reg_sel;
		bfiu_op_t   op;
	} bfiu_cmd_t;

	// shifter result with its flags
	typedef struct packed {
		logic [7:0] dout;
		logic       c;
		logic       z;
		logic       n;
		logic       v;
	} bfiu_shift_res_t;

endpackage : bfiu_pkg

// [hdl/bfiu_bit_mod.sv]
`timescale 1ns/1ps
// replaces one selected bit of a word by a given value
module bfiu_bit_mod #(
	parameter int W = 8
) (
	input  wire logic [W-1:0]         din,
	input  wire logic [$clog2(W)-1:0] sel,
	input  wire logic                 val,
	output logic      [W-1:0]         dout
);

	// one mux per bit position
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign dout[i] = (sel == ($clog2(W))'(i)) ? val : din[i];
	end

endmodule : bfiu_bit_mod

// [hdl/bfiu_shift_unit.sv]
`timescale 1ns/1ps
// combinational rotate, shift and swap with flag results
module bfiu_shift_unit (
	input  wire bfiu_pkg::bfiu_op_t   op,
	input  wire logic [7:0]           din,
	input  wire logic                 cin,
	output bfiu_pkg::bfiu_shift_res_t res
);

	wire [7:0] rot_l   = {din[6:0], cin};        // RULE_03
	wire [7:0] rot_r   = {cin, din[7:1]};        // RULE_04
	wire [7:0] shl     = {din[6:0], 1'b0};       // RULE_12
	wire [7:0] shr     = {1'b0, din[7:1]};       // RULE_12
	wire [7:0] ashr    = {din[7], din[7:1]};     // RULE_12
	wire [7:0] swp     = {din[3:0], din[7:4]};   // RULE_13
	// right-moving ops spill bit 0, left-moving spill bit 7
	wire       right   = (op == bfiu_pkg::rotate_right_carry_op) || (op == bfiu_pkg::shift_right_op) ||
	                     (op == bfiu_pkg::arith_shift_right_op);
	wire [7:0] result  = (op == bfiu_pkg::rotate_left_carry_op)  ? rot_l :
	                     (op == bfiu_pkg::rotate_right_carry_op) ? rot_r :
	                     (op == bfiu_pkg::shift_left_op)         ? shl   :
	                     (op == bfiu_pkg::shift_right_op)        ? shr   :
	                     (op == bfiu_pkg::arith_shift_right_op)  ? ashr  : swp;
	wire       carry   = right ? din[0] : din[7];   // RULE_03 RULE_04 RULE_12

	assign res.dout = result;
	assign res.c    = carry;
	assign res.z    = (result == 8'h00);
	assign res.n    = result[7];
	assign res.v    = result[7] ^ carry;

endmodule : bfiu_shift_unit

// [hdl/bfiu_top.sv]
`timescale 1ns/1ps
`include "bfiu_defs.svh"
// bit, flag and mcu-control instruction unit with apb access
module bfiu_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             sleep_req,
	output logic             wdog_restart,
	output logic             debug_break
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	bfiu_pkg::bfiu_state_t     state_ff;          // sequencer state
	bfiu_pkg::bfiu_state_t     nxt_state;         // next sequencer state
	bfiu_pkg::bfiu_cmd_t       cmd_ff;            // instruction being executed
	logic [7:0]                flag_register_ff;  // status flags
	logic [7:0]                nxt_flag_register; // next status flags
	logic                      halted_ff;         // debug stop pending
	logic                      sleep_ff;          // sleep request pulse
	logic                      wdog_ff;           // watchdog restart pulse
	logic                      pready_ff;         // apb ready
	logic                      pslverr_ff;        // apb error
	logic [31:0]               prdata_ff;         // apb read data
	logic [7:0]                io_tmp_ff;         // io value read in first io cycle
	logic [7:0]                wreg_q [32];       // working registers
	logic [7:0]                io_q [64];         // io registers
	bfiu_pkg::bfiu_shift_res_t sh_res;            // shifter output
	logic [7:0]                bld_out;           // register with transfer flag inserted
	logic [7:0]                io_out;            // io value with bit forced

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	wire        busy      = (state_ff != bfiu_pkg::st_idle);
	wire        access    = psel & penable;
	wire        wr_stall  = pwrite & busy;            // writes wait for the sequencer
	wire        take      = access & ~pready_ff & ~wr_stall;
	wire        apb_done  = access & pready_ff;
	wire        aligned   = (paddr[1:0] == 2'b00);
	wire        hit_cmd   = (paddr == `BFIU_CMD_OFS);
	wire        hit_st    = (paddr == `BFIU_STATUS_OFS);
	wire        hit_fl    = (paddr == `BFIU_FLAGS_OFS);
	wire        hit_wreg  = (paddr[11:7] == `BFIU_WREG_BASE) & aligned;
	wire        hit_io    = (paddr[11:8] == `BFIU_IO_BASE) & aligned;
	wire [4:0]  wreg_idx  = paddr[6:2];
	wire [5:0]  io_idx    = paddr[7:2];
	wire        mapped    = hit_cmd | hit_st | hit_fl | hit_wreg | hit_io;
	// a command is refused while a debug stop is pending
	wire        bad       = ~mapped | (hit_cmd & pwrite & halted_ff);
	wire        apb_wr    = apb_done & pwrite & ~pslverr_ff;
	wire [31:0] status_rd = {16'h0000, flag_register_ff, 6'h00, halted_ff, busy};
	wire [31:0] rd_mux    = hit_cmd  ? {13'h0000, cmd_ff}        :
	                        hit_st   ? status_rd                 :
	                        hit_fl   ? {24'h000000, flag_register_ff} :
	                        hit_wreg ? {24'h000000, wreg_q[wreg_idx]} :
	                        hit_io   ? {24'h000000, io_q[io_idx]} : 32'h00000000;

	// apb answer: ready one cycle into the access phase, later if stalled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end
		else
		begin
			pready_ff  <= take;
			pslverr_ff <= take & bad;
			if (take)
				prdata_ff <= (pwrite | bad) ? 32'h00000000 : rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command decode

	wire                   cmd_start = apb_wr & hit_cmd;
	bfiu_pkg::bfiu_cmd_t   cmd_new;
	assign cmd_new = bfiu_pkg::bfiu_cmd_t'(pwdata[18:0]);
	wire                   op_is_io  = (cmd_new.op == bfiu_pkg::io_bit_set_op) ||
	                                   (cmd_new.op == bfiu_pkg::io_bit_clear_op);
	wire                   exec      = (state_ff == bfiu_pkg::st_exec);
	wire bfiu_pkg::bfiu_op_t op      = cmd_ff.op;
	wire                   op_shift  = (op == bfiu_pkg::rotate_left_carry_op) ||
	                                   (op == bfiu_pkg::rotate_right_carry_op) ||
	                                   (op == bfiu_pkg::shift_left_op) ||
	                                   (op == bfiu_pkg::shift_right_op) ||
	                                   (op == bfiu_pkg::arith_shift_right_op);
	wire [7:0]             wreg_src  = wreg_q[cmd_ff.reg_sel];

	// next state: io ops take two cycles, all others one
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			bfiu_pkg::st_idle:
				if (cmd_start)
					nxt_state = op_is_io ? bfiu_pkg::st_io_read : bfiu_pkg::st_exec;   // RULE_01 RULE_02
			bfiu_pkg::st_exec:
				nxt_state = bfiu_pkg::st_idle;
			bfiu_pkg::st_io_read:
				nxt_state = bfiu_pkg::st_io_write;
			bfiu_pkg::st_io_write:
				nxt_state = bfiu_pkg::st_idle;
		endcase
	end

	// sequencer and command latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= bfiu_pkg::st_idle;
			cmd_ff   <= bfiu_pkg::bfiu_cmd_t'(`BFIU_CMD_RST);
		end
		else
		begin
			state_ff <= nxt_state;
			if (cmd_start)
				cmd_ff <= cmd_new;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// datapath

	// shift, rotate and swap
	bfiu_shift_unit u_shift (
		.op  (op),
		.din (wreg_src),
		.cin (flag_register_ff[`BFIU_FLAG_C]),
		.res (sh_res)
	);

	// transfer flag into register bit
	bfiu_bit_mod #(.W(8)) u_bld (
		.din  (wreg_src),
		.sel  (cmd_ff.bit_sel),
		.val  (flag_register_ff[`BFIU_FLAG_T]),   // RULE_06
		.dout (bld_out)
	);

	// io bit forced to one for set, zero for clear
	bfiu_bit_mod #(.W(8)) u_iobit (
		.din  (io_tmp_ff),
		.sel  (cmd_ff.bit_sel),
		.val  (op == bfiu_pkg::io_bit_set_op),    // RULE_01 RULE_02
		.dout (io_out)
	);

	// working register write port: apb when idle, sequencer when executing
	wire       wreg_exec = exec & (op_shift | (op == bfiu_pkg::nibble_swap_op) ||
	                       (op == bfiu_pkg::transfer_flag_to_bit_op));
	wire       wreg_we   = (apb_wr & hit_wreg) | wreg_exec;
	wire [4:0] wreg_wa   = wreg_exec ? cmd_ff.reg_sel : wreg_idx;
	wire [7:0] wreg_wd   = ~wreg_exec ? pwdata[7:0] :
	                       (op == bfiu_pkg::transfer_flag_to_bit_op) ? bld_out : sh_res.dout;   // RULE_06 RULE_13
	wire       io_exec   = (state_ff == bfiu_pkg::st_io_write);
	wire       io_we     = (apb_wr & hit_io) | io_exec;
	wire [5:0] io_wa     = io_exec ? cmd_ff.io_addr : io_idx;
	wire [7:0] io_wd     = io_exec ? io_out : pwdata[7:0];

	// register arrays, no reset
	always_ff @(posedge pclk)
	begin
		if (wreg_we)
			wreg_q[wreg_wa] <= wreg_wd;
		if (io_we)
			io_q[io_wa] <= io_wd;   // RULE_01 RULE_02
		if (state_ff == bfiu_pkg::st_io_read)
			io_tmp_ff <= io_q[cmd_ff.io_addr];
	end

	////////////////////////////////////////////////////////////////////////////////
	// flags

	// next flags: software write when idle, else instruction effect
	always_comb
	begin
		nxt_flag_register = flag_register_ff;
		if (apb_wr & hit_fl)
			nxt_flag_register = pwdata[7:0];
		else if (exec)
		begin
			unique case (op)
				bfiu_pkg::rotate_left_carry_op, bfiu_pkg::rotate_right_carry_op,
				bfiu_pkg::shift_left_op, bfiu_pkg::shift_right_op, bfiu_pkg::arith_shift_right_op:
				begin
					nxt_flag_register[`BFIU_FLAG_C] = sh_res.c;              // RULE_03 RULE_04 RULE_12
					nxt_flag_register[`BFIU_FLAG_Z] = sh_res.z;
					nxt_flag_register[`BFIU_FLAG_N] = sh_res.n;
					nxt_flag_register[`BFIU_FLAG_V] = sh_res.v;
					nxt_flag_register[`BFIU_FLAG_S] = sh_res.n ^ sh_res.v;
				end
				bfiu_pkg::bit_to_transfer_flag_op:
					nxt_flag_register[`BFIU_FLAG_T] = wreg_src[cmd_ff.bit_sel];   // RULE_05
				bfiu_pkg::half_carry_set_op:
					nxt_flag_register[`BFIU_FLAG_H] = 1'b1;                  // RULE_07
				bfiu_pkg::half_carry_clear_op:
					nxt_flag_register[`BFIU_FLAG_H] = 1'b0;                  // RULE_07
				bfiu_pkg::sign_flag_set_op:
					nxt_flag_register[`BFIU_FLAG_S] = 1'b1;                  // RULE_08
				default:
					nxt_flag_register = flag_register_ff;   // no flag effect, illegal codes as nop
			endcase
		end
	end

	// flag register, control pulses and debug stop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_register_ff <= `BFIU_FLAGS_RST;
			sleep_ff         <= 1'b0;
			wdog_ff          <= 1'b0;
			halted_ff        <= 1'b0;
		end
		else
		begin
			flag_register_ff <= nxt_flag_register;
			sleep_ff         <= exec & (op == bfiu_pkg::sleep_op);              // RULE_09
			wdog_ff          <= exec & (op == bfiu_pkg::watchdog_restart_op);   // RULE_10
			// the break sets the stop, software releases it; the set wins
			if (exec & (op == bfiu_pkg::break_op))
				halted_ff <= 1'b1;                                              // RULE_11
			else if (apb_wr & hit_st & pwdata[`BFIU_ST_HALT_BIT])
				halted_ff <= 1'b0;
		end
	end

	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
	assign sleep_req    = sleep_ff;
	assign wdog_restart = wdog_ff;
	assign debug_break  = halted_ff;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// io op: read cycle, then write cycle
	sequence s_io_run;
		(state_ff == bfiu_pkg::st_io_read) ##1 (state_ff == bfiu_pkg::st_io_write);
	endsequence

	a_io_set_bit: assert property (   // RULE_01
		(state_ff == bfiu_pkg::st_io_read) && (op == bfiu_pkg::io_bit_set_op)
		|-> s_io_run ##1 (io_q[cmd_ff.io_addr][cmd_ff.bit_sel] && !busy &&
		flag_register_ff == $past(flag_register_ff, 2)))
		else $error("io bit set wrong");
	a_io_clear_bit: assert property (   // RULE_02
		(state_ff == bfiu_pkg::st_io_read) && (op == bfiu_pkg::io_bit_clear_op)
		|-> s_io_run ##1 (!io_q[cmd_ff.io_addr][cmd_ff.bit_sel] && !busy &&
		flag_register_ff == $past(flag_register_ff, 2)))
		else $error("io bit clear wrong");
	a_rot_left: assert property (   // RULE_03
		exec && op == bfiu_pkg::rotate_left_carry_op
		|=> wreg_q[cmd_ff.reg_sel] == {$past(wreg_src[6:0]), $past(flag_register_ff[`BFIU_FLAG_C])} &&
		flag_register_ff[`BFIU_FLAG_C] == $past(wreg_src[7]))
		else $error("rotate left wrong");
	a_rot_right: assert property (   // RULE_04
		exec && op == bfiu_pkg::rotate_right_carry_op
		|=> wreg_q[cmd_ff.reg_sel] == {$past(flag_register_ff[`BFIU_FLAG_C]), $past(wreg_src[7:1])} &&
		flag_register_ff[`BFIU_FLAG_C] == $past(wreg_src[0]))
		else $error("rotate right wrong");
	a_bit_to_t: assert property (   // RULE_05
		exec && op == bfiu_pkg::bit_to_transfer_flag_op
		|=> flag_register_ff[`BFIU_FLAG_T] == $past(wreg_src[cmd_ff.bit_sel]) && !busy)
		else $error("transfer flag load wrong");
	a_t_to_bit: assert property (   // RULE_06
		exec && op == bfiu_pkg::transfer_flag_to_bit_op
		|=> wreg_q[cmd_ff.reg_sel][cmd_ff.bit_sel] == $past(flag_register_ff[`BFIU_FLAG_T]))
		else $error("transfer flag store wrong");
	a_half_carry: assert property (   // RULE_07
		exec && (op == bfiu_pkg::half_carry_set_op || op == bfiu_pkg::half_carry_clear_op)
		|=> flag_register_ff == {$past(flag_register_ff[7:6]), $past(op == bfiu_pkg::half_carry_set_op),
		$past(flag_register_ff[4:0])})
		else $error("half carry wrong");
	a_sign_set: assert property (   // RULE_08
		exec && op == bfiu_pkg::sign_flag_set_op
		|=> flag_register_ff == ($past(flag_register_ff) | 8'h10))
		else $error("signed flag wrong");
	a_sleep_pulse: assert property (   // RULE_09
		exec && op == bfiu_pkg::sleep_op
		|=> sleep_req && flag_register_ff == $past(flag_register_ff) ##1 !sleep_req)
		else $error("sleep pulse wrong");
	a_wdog_pulse: assert property (   // RULE_10
		$rose(wdog_restart) |-> $past(exec && op == bfiu_pkg::watchdog_restart_op) ##1 !wdog_restart)
		else $error("watchdog pulse wrong");
	a_break_stop: assert property (   // RULE_11
		exec && op == bfiu_pkg::break_op
		|=> debug_break && flag_register_ff == $past(flag_register_ff))
		else $error("break stop wrong");
	a_shift_left: assert property (   // RULE_12
		exec && op == bfiu_pkg::shift_left_op
		|=> wreg_q[cmd_ff.reg_sel] == {$past(wreg_src[6:0]), 1'b0} &&
		flag_register_ff[`BFIU_FLAG_C] == $past(wreg_src[7]))
		else $error("shift left wrong");
	a_nibble_swap: assert property (   // RULE_13
		exec && op == bfiu_pkg::nibble_swap_op
		|=> wreg_q[cmd_ff.reg_sel] == {$past(wreg_src[3:0]), $past(wreg_src[7:4])} &&
		$stable(flag_register_ff))
		else $error("nibble swap wrong");

	// right shifts, untouched bits, watchdog flags and the refused command
	a_shift_right: assert property (   // RULE_12
		exec && op == bfiu_pkg::shift_right_op
		|=> wreg_q[cmd_ff.reg_sel] == {1'b0, $past(wreg_src[7:1])} &&
		flag_register_ff[`BFIU_FLAG_C] == $past(wreg_src[0]))
		else $error("shift right wrong");
	a_arith_shift: assert property (   // RULE_12
		exec && op == bfiu_pkg::arith_shift_right_op
		|=> wreg_q[cmd_ff.reg_sel] == {$past(wreg_src[7]), $past(wreg_src[7:1])} &&
		flag_register_ff[`BFIU_FLAG_C] == $past(wreg_src[0]))
		else $error("arithmetic shift wrong");
	a_bit_others: assert property (   // RULE_06
		exec && op == bfiu_pkg::transfer_flag_to_bit_op
		|=> ((wreg_q[cmd_ff.reg_sel] ^ $past(wreg_src)) & ~(8'h01 << cmd_ff.bit_sel)) == 8'h00)
		else $error("transfer flag store touched other bits");
	a_wdog_flags: assert property (   // RULE_10
		exec && op == bfiu_pkg::watchdog_restart_op
		|=> wdog_restart && $stable(flag_register_ff))
		else $error("watchdog restart changed flags");
	a_cmd_refused: assert property (   // RULE_11
		apb_done && pwrite && hit_cmd && halted_ff
		|-> pslverr ##1 (!busy && $stable(cmd_ff)))
		else $error("command taken while stopped");

endmodule : bfiu_top

// [verification/bfiu_far_model.sv]
`timescale 1ns/1ps
// stands for the power, watchdog and debug logic fed by the unit
module bfiu_far_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic sleep_req,
	input  wire logic wdog_restart,
	input  wire logic debug_break,
	output int        sleep_cnt_ff,
	output int        wdog_cnt_ff,
	output int        brk_cnt_ff,
	output int        wide_cnt_ff
);
	logic prev_ff; // last strobe levels, to catch long pulses
	logic prev_brk_ff; // last stop level, to count new stops
	// one event per strobe cycle; a strobe held twice is counted as wide
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_cnt_ff <= 0;
			wdog_cnt_ff <= 0;
			brk_cnt_ff <= 0;
			wide_cnt_ff <= 0;
			prev_ff <= 1'b0;
			prev_brk_ff <= 1'b0;
		end
		else
		begin
			sleep_cnt_ff <= sleep_cnt_ff + int'(sleep_req);
			wdog_cnt_ff <= wdog_cnt_ff + int'(wdog_restart);
			brk_cnt_ff <= brk_cnt_ff + int'(debug_break && !prev_brk_ff);
			wide_cnt_ff <= wide_cnt_ff + int'(prev_ff && (sleep_req || wdog_restart));
			prev_ff <= sleep_req || wdog_restart;
			prev_brk_ff <= debug_break;
		end
	end
endmodule : bfiu_far_model

// [verification/bit_flag_instruction_unit_test.sv]
`timescale 1ns/1ps
// drives the unit over apb and judges register and strobe results
module bit_flag_instruction_unit_test;
	localparam logic [11:0] CMD_A = 12'h000;
	localparam logic [11:0] ST_A  = 12'h004;
	localparam logic [11:0] FL_A  = 12'h008;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        sleep_req, wdog_restart, debug_break;
	int          sleep_cnt, wdog_cnt, brk_cnt, wide_cnt, errors, checks_done;
	// 100 ns clock
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;
	bfiu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_req(sleep_req), .wdog_restart(wdog_restart), .debug_break(debug_break));
	bfiu_far_model far_u (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
		.wdog_restart(wdog_restart), .debug_break(debug_break), .sleep_cnt_ff(sleep_cnt),
		.wdog_cnt_ff(wdog_cnt), .brk_cnt_ff(brk_cnt), .wide_cnt_ff(wide_cnt));
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ee);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			$display("wrong value pready expected 1 seen %b", pready);
			tally_and_finish();
		end
		else
		begin
			rd = prdata;
			chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 1'b0);
		chk(what, exp, rd);
	endtask : rchk
	function automatic logic [31:0] mkcmd(input bfiu_pkg::bfiu_op_t op, input logic [4:0] r,
		input logic [2:0] b, input logic [5:0] io);
		bfiu_pkg::bfiu_cmd_t c;
		c = '{io, b, r, op};
		return {13'h0, c};
	endfunction : mkcmd
	// issue a command, then poll busy until the sequencer is idle
	task automatic cmd(input bfiu_pkg::bfiu_op_t op, input logic [4:0] r, input logic [2:0] b,
		input logic [5:0] io);
		int n;
		apb(1'b1, CMD_A, mkcmd(op, r, b, io), 1'b0);
		n = 0;
		do
		begin
			apb(1'b0, ST_A, 32'h0, 1'b0);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 10);
		chk("busy", 32'h0, {31'h0, rd[0]});
		if (rd[0] !== 1'b0)
			tally_and_finish();
	endtask : cmd
	// expected {flags, data} of a shift, rotate or swap
	function automatic logic [15:0] shf(input bfiu_pkg::bfiu_op_t op, input logic [7:0] d,
		input logic [7:0] f);
		logic [7:0] r;
		logic       co, n;
		case (op)
			bfiu_pkg::rotate_left_carry_op: {co, r} = {d, f[0]};
			bfiu_pkg::rotate_right_carry_op: {r, co} = {f[0], d};
			bfiu_pkg::shift_left_op: {co, r} = {d, 1'b0};
			bfiu_pkg::shift_right_op: {r, co} = {1'b0, d};
			bfiu_pkg::arith_shift_right_op: {r, co} = {d[7], d};
			default: return {f, d[3:0], d[7:4]};
		endcase
		n = r[7];
		return {f[7:5], co, n ^ co, n, r == 8'h00, co, r};
	endfunction : shf
	////////////////////////////////////////////////////////////////////////
	task automatic t_io_bits;
		apb(1'b1, 12'h214, 32'h5a, 1'b0);
		apb(1'b1, 12'h2fc, 32'h00, 1'b0);
		apb(1'b1, FL_A, 32'h2b, 1'b0);
		cmd(bfiu_pkg::io_bit_set_op, 5'h0, 3'h7, 6'h05);
		rchk("io set", 12'h214, 32'hda);
		cmd(bfiu_pkg::io_bit_set_op, 5'h0, 3'h0, 6'h3f);
		rchk("io set last", 12'h2fc, 32'h01);
		cmd(bfiu_pkg::io_bit_clear_op, 5'h0, 3'h1, 6'h05);
		rchk("io clear", 12'h214, 32'hd8);
		rchk("flags after io", FL_A, 32'h2b);
		$display("done io bits");
	endtask : t_io_bits
	task automatic t_shifts;
		bfiu_pkg::bfiu_op_t ops[6] = '{bfiu_pkg::rotate_left_carry_op, bfiu_pkg::rotate_right_carry_op,
			bfiu_pkg::shift_left_op, bfiu_pkg::shift_right_op, bfiu_pkg::arith_shift_right_op,
			bfiu_pkg::nibble_swap_op};
		logic [7:0] din[3] = '{8'h81, 8'h01, 8'h80};
		logic [7:0] fin[3] = '{8'he0, 8'h61, 8'h21};
		logic [15:0] e;
		logic [11:0] a;
		for (int i = 0; i < 6; i++)
			for (int j = 0; j < 3; j++)
			begin
				a = 12'h100 + 12'((i * 5 + j + 4) * 4);
				e = shf(ops[i], din[j], fin[j]);
				apb(1'b1, a, {24'h0, din[j]}, 1'b0);
				apb(1'b1, FL_A, {24'h0, fin[j]}, 1'b0);
				cmd(ops[i], 5'(i * 5 + j + 4), 3'h0, 6'h0);
				rchk("shift data", a, {24'h0, e[7:0]});
				rchk("shift flags", FL_A, {24'h0, e[15:8]});
			end
		$display("done shifts");
	endtask : t_shifts
	task automatic t_transfer;
		apb(1'b1, 12'h11c, 32'h20, 1'b0);
		apb(1'b1, 12'h124, 32'hf7, 1'b0);
		apb(1'b1, FL_A, 32'h00, 1'b0);
		cmd(bfiu_pkg::bit_to_transfer_flag_op, 5'h07, 3'h5, 6'h0);
		rchk("t set", FL_A, 32'h40);
		cmd(bfiu_pkg::transfer_flag_to_bit_op, 5'h09, 3'h3, 6'h0);
		rchk("bit from t", 12'h124, 32'hff);
		cmd(bfiu_pkg::bit_to_transfer_flag_op, 5'h07, 3'h4, 6'h0);
		rchk("t clear", FL_A, 32'h00);
		cmd(bfiu_pkg::transfer_flag_to_bit_op, 5'h09, 3'h0, 6'h0);
		rchk("bit zero from t", 12'h124, 32'hfe);
		rchk("source kept", 12'h11c, 32'h20);
		$display("done transfer flag");
	endtask : t_transfer
	task automatic t_flags;
		apb(1'b1, FL_A, 32'h00, 1'b0);
		cmd(bfiu_pkg::half_carry_set_op, 5'h0, 3'h0, 6'h0);
		rchk("h set", FL_A, 32'h20);
		cmd(bfiu_pkg::sign_flag_set_op, 5'h0, 3'h0, 6'h0);
		rchk("s set", FL_A, 32'h30);
		apb(1'b1, FL_A, 32'hff, 1'b0);
		cmd(bfiu_pkg::half_carry_clear_op, 5'h0, 3'h0, 6'h0);
		rchk("h clear", FL_A, 32'hdf);
		apb(1'b1, FL_A, 32'hef, 1'b0);
		cmd(bfiu_pkg::sign_flag_set_op, 5'h0, 3'h0, 6'h0);
		rchk("s set others", FL_A, 32'hff);
		$display("done flag ops");
	endtask : t_flags
	task automatic t_mcu;
		int s;
		int w;
		s = sleep_cnt;
		w = wdog_cnt;
		apb(1'b1, FL_A, 32'h5a, 1'b0);
		cmd(bfiu_pkg::sleep_op, 5'h0, 3'h0, 6'h0);
		chk("sleep strobes", 32'(s + 1), 32'(sleep_cnt));
		cmd(bfiu_pkg::watchdog_restart_op, 5'h0, 3'h0, 6'h0);
		chk("watchdog strobes", 32'(w + 1), 32'(wdog_cnt));
		chk("sleep strobes kept", 32'(s + 1), 32'(sleep_cnt));
		chk("long strobes", 32'h0, 32'(wide_cnt));
		rchk("flags after mcu", FL_A, 32'h5a);
		$display("done sleep and watchdog");
	endtask : t_mcu
	task automatic t_break;
		int s;
		s = sleep_cnt;
		cmd(bfiu_pkg::break_op, 5'h0, 3'h0, 6'h0);
		chk("stop level", 32'h1, {31'h0, debug_break});
		rchk("stop pending", ST_A, {16'h0, 8'h5a, 8'h02});
		apb(1'b1, CMD_A, mkcmd(bfiu_pkg::sleep_op, 5'h0, 3'h0, 6'h0), 1'b1);
		apb(1'b1, ST_A, 32'h2, 1'b0);
		rchk("stop cleared", ST_A, 32'h00005a00);
		chk("no sleep while stopped", 32'(s), 32'(sleep_cnt));
		chk("stop released", 32'h0, {31'h0, debug_break});
		chk("stops seen", 32'h1, 32'(brk_cnt));
		$display("done break");
	endtask : t_break
	task automatic t_refuse;
		apb(1'b0, 12'h00c, 32'h0, 1'b1);
		chk("refused read data", 32'h0, rd);
		apb(1'b1, 12'h101, 32'hff, 1'b1);
		apb(1'b0, 12'h300, 32'h0, 1'b1);
		$display("done refused");
	endtask : t_refuse
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		errors = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk("strobes at reset", 32'h0, {29'h0, sleep_req, wdog_restart, debug_break});
		rchk("flags at reset", FL_A, 32'h0);
		t_io_bits();
		t_shifts();
		t_transfer();
		t_flags();
		t_mcu();
		t_break();
		t_refuse();
		tally_and_finish();
	end
endmodule : bit_flag_instruction_unit_test
